// file: src/dsoc_pkg.sv
// Functional notes
// - add signed 13-bit offset to output code
// - dither on: clamp offset to +/-128
// - dither off: clamp offset to +/-3968
// - two offset entries, channel 0 lower, reset zero
// - host changes offset only when safe
// - host holds reset until clock runs
// - fuse load sets done; host waits
// - host takes total interp equal upconv factor
// - host starts transmitter before receiver enable
// - data reaches converters only with datapath enable
// - host waits 80 us after datapath enable
// - host enables sysref steps in order
// - source delivers at least five sysref pulses
// - device reports link, lock, aligned, lane status
// - host clears both enables before reconfiguring
// - synthesis starts only with datapath enable too
// - stream count 2/4/6/8 gives 1-4 synth channels
// - synthesis implies oscillator enable
// - complex synthesis uses stream count 2 or 4
// - new synth values apply at resync; readback
// - host programs multiframe count to match partner
package dsoc_pkg;
   // ------------------------------------------------------------
   // device register map (byte addresses on the device port)
   // ------------------------------------------------------------
   localparam logic [11:0] DSOC_ADDR_OFS0   = 12'h72A;
   localparam logic [11:0] DSOC_ADDR_OFS1   = 12'h72B;
   localparam logic [11:0] DSOC_ADDR_DITH   = 12'h729;
   localparam logic [11:0] DSOC_ADDR_CTRL   = 12'h100;
   localparam logic [11:0] DSOC_ADDR_SYNTH  = 12'h101;
   localparam logic [11:0] DSOC_ADDR_SREF   = 12'h102;
   localparam logic [11:0] DSOC_ADDR_STAT   = 12'h103;
   localparam logic [11:0] DSOC_ADDR_LANE   = 12'h104;
   localparam logic [11:0] DSOC_ADDR_FREQ   = 12'h105;
   localparam logic [11:0] DSOC_ADDR_FREQ_R = 12'h106;
   localparam logic [11:0] DSOC_ADDR_RESYNC = 12'h107;
   localparam logic [11:0] DSOC_ADDR_KM1    = 12'h108;
   // field positions
   localparam int DSOC_OFS_W        = 13;
   localparam int DSOC_CTRL_DP      = 0;
   localparam int DSOC_CTRL_LINK    = 1;
   localparam int DSOC_CTRL_BLK     = 2;
   localparam int DSOC_SYN_EN       = 0;
   localparam int DSOC_SYN_FMT      = 1;
   localparam int DSOC_SYN_OSC      = 2;
   localparam int DSOC_SREF_SLEEP   = 0;
   localparam int DSOC_SREF_PROC    = 1;
   localparam int DSOC_SREF_ALIGN   = 2;
   localparam int DSOC_ST_FUSE      = 0;
   localparam int DSOC_ST_LINK      = 1;
   localparam int DSOC_ST_PLL       = 2;
   localparam int DSOC_ST_ALIGN     = 3;
   localparam int DSOC_ST_SYNTH     = 4;
   localparam int DSOC_ST_NCH       = 5;   // 3 bits
   // dither field codes: 3 means dither off
   localparam logic [1:0] DSOC_DITH_OFF = 2'h3;
   localparam logic [7:0] DSOC_DITH_RST = 8'h00;
   localparam logic [7:0] DSOC_SREF_RST = 8'h01;  // receiver asleep
   // saturation limits
   localparam logic signed [12:0] DSOC_LIM_DITH = 13'sh0080;
   localparam logic signed [12:0] DSOC_LIM_FULL = 13'sh0F80;
   // timing
   localparam int DSOC_CLK_MHZ       = 50;
   localparam int DSOC_DP_SETTLE_US  = 80;
   localparam int DSOC_DP_SETTLE_CYC = DSOC_DP_SETTLE_US * DSOC_CLK_MHZ;
   localparam int DSOC_FUSE_CYC      = 16;
   localparam int DSOC_SREF_PULSES   = 5;
   // apb controller map
   localparam logic [7:0] DSOC_APB_CMD   = 8'h00;
   localparam logic [7:0] DSOC_APB_STAT  = 8'h04;
   localparam logic [7:0] DSOC_APB_ADDR  = 8'h08;
   localparam logic [7:0] DSOC_APB_WDATA = 8'h0C;
   localparam logic [7:0] DSOC_APB_RDATA = 8'h10;
   localparam logic [7:0] DSOC_APB_MODE  = 8'h14;
   localparam logic [7:0] DSOC_APB_OFS   = 8'h18;
   localparam logic [7:0] DSOC_APB_SYN   = 8'h1C;
   localparam logic [31:0] DSOC_APB_ERRV = 32'hDEAD_BEEF;
   localparam int DSOC_CMD_START = 0;
   localparam int DSOC_CMD_RAW   = 1;
   localparam int DSOC_CMD_RECFG = 2;
endpackage

// file: src/dsoc_if.sv
// device register port plus link side pins between host and device
interface dsoc_if;
   import dsoc_pkg::*;
   logic        reg_wr;
   logic        reg_rd;
   logic [11:0] reg_addr;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic        reg_rvalid;
   logic        tx_running;   // transmitter streaming
   logic        sysref;       // sysref pulse, one cycle
   modport dev  (input reg_wr, reg_rd, reg_addr, reg_wdata, tx_running,
                 sysref, output reg_rdata, reg_rvalid);
   modport host (output reg_wr, reg_rd, reg_addr, reg_wdata, tx_running,
                 sysref, input reg_rdata, reg_rvalid);
endinterface

// file: src/dsoc_device.sv
module dsoc_device
   import dsoc_pkg::*;
#(
   parameter int CH = 2
) (
   input  wire logic                 clk,
   input  wire logic                 rst,
   dsoc_if.dev                       bus,
   input  wire logic signed [15:0]   sample_in [CH],
   input  wire logic                 pll_locked_in,
   output logic signed [15:0]        dac_out [CH],
   output logic                      dac_valid
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic signed [12:0] ofs [CH];
   logic [7:0]  dith;
   logic [2:0]  ctrl;
   logic [2:0]  synth;
   logic [3:0]  stream_count;
   logic [2:0]  sref;
   logic [15:0] freq, freq_r;
   logic [7:0]  km1;
   logic [4:0]  fuse_cnt;
   logic        fuse_done;
   logic [2:0]  pulse_cnt;
   logic        aligned;
   logic [3:0]  lane_sync;
   logic        pll_s0, pll_s1;
   logic        link_up;
   logic        synth_active;
   logic [2:0]  synth_nch;

   // fuse load after reset release
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fuse_cnt  <= 5'h00;
         fuse_done <= 1'b0;
      end else if (!fuse_done) begin
         fuse_cnt <= fuse_cnt + 5'h01;
         if (fuse_cnt == 5'(DSOC_FUSE_CYC - 1)) begin
            fuse_done <= 1'b1;
         end
      end
   end

   // register writes; writes before fuse done are dropped
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < CH; i++) ofs[i] <= '0;
         dith         <= DSOC_DITH_RST;
         ctrl         <= 3'h0;
         synth        <= 3'h0;
         stream_count <= 4'h0;
         sref         <= DSOC_SREF_RST[2:0];
         freq         <= 16'h0000;
         km1          <= 8'h00;
      end else if (bus.reg_wr && fuse_done) begin
         if (bus.reg_addr == DSOC_ADDR_OFS0) begin
            ofs[0] <= bus.reg_wdata[DSOC_OFS_W-1:0];
         end else if (bus.reg_addr == DSOC_ADDR_OFS1) begin
            ofs[1] <= bus.reg_wdata[DSOC_OFS_W-1:0];
         end else if (bus.reg_addr == DSOC_ADDR_DITH) begin
            dith <= bus.reg_wdata[7:0];
         end else if (bus.reg_addr == DSOC_ADDR_CTRL) begin
            ctrl <= bus.reg_wdata[2:0];
         end else if (bus.reg_addr == DSOC_ADDR_SYNTH) begin
            synth        <= bus.reg_wdata[2:0];
            stream_count <= bus.reg_wdata[7:4];
         end else if (bus.reg_addr == DSOC_ADDR_SREF) begin
            sref <= bus.reg_wdata[2:0];
         end else if (bus.reg_addr == DSOC_ADDR_FREQ) begin
            freq <= bus.reg_wdata;
         end else if (bus.reg_addr == DSOC_ADDR_KM1) begin
            km1 <= bus.reg_wdata[7:0];
         end
      end
   end

   // staged synth value applies only on resync write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         freq_r <= 16'h0000;
      end else if (bus.reg_wr && fuse_done &&
                   bus.reg_addr == DSOC_ADDR_RESYNC) begin
         freq_r <= freq;
      end
   end

   // sysref alignment: count pulses once enabled
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pulse_cnt <= 3'h0;
         aligned   <= 1'b0;
      end else if (!sref[DSOC_SREF_ALIGN] || sref[DSOC_SREF_SLEEP] ||
                   !sref[DSOC_SREF_PROC]) begin
         pulse_cnt <= 3'h0;
         aligned   <= 1'b0;
      end else if (bus.sysref && !aligned) begin
         pulse_cnt <= pulse_cnt + 3'h1;
         if (pulse_cnt == 3'(DSOC_SREF_PULSES - 1)) begin
            aligned <= 1'b1;
         end
      end
   end

   // pll lock pin is asynchronous: two flops first
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pll_s0 <= 1'b0;
         pll_s1 <= 1'b0;
      end else begin
         pll_s0 <= pll_locked_in;
         pll_s1 <= pll_s0;
      end
   end

   // lanes sync when receiver enabled and transmitter running
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lane_sync <= 4'h0;
      end else begin
         lane_sync <= {4{ctrl[DSOC_CTRL_LINK] && bus.tx_running}};
      end
   end

   // synthesis needs datapath enable and receiver off
   always_comb begin
      synth_active = synth[DSOC_SYN_EN] && ctrl[DSOC_CTRL_DP] &&
                     !ctrl[DSOC_CTRL_LINK];
      synth_nch = 3'(stream_count >> 1);
      link_up   = pll_s1 && (&lane_sync) && aligned;
   end

   // readback; unmapped reads return zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bus.reg_rdata  <= 16'h0000;
         bus.reg_rvalid <= 1'b0;
      end else begin
         bus.reg_rvalid <= bus.reg_rd;
         if (bus.reg_addr == DSOC_ADDR_OFS0) begin
            bus.reg_rdata <= {3'h0, ofs[0]};
         end else if (bus.reg_addr == DSOC_ADDR_OFS1) begin
            bus.reg_rdata <= {3'h0, ofs[1]};
         end else if (bus.reg_addr == DSOC_ADDR_DITH) begin
            bus.reg_rdata <= {8'h00, dith};
         end else if (bus.reg_addr == DSOC_ADDR_CTRL) begin
            bus.reg_rdata <= {13'h0000, ctrl};
         end else if (bus.reg_addr == DSOC_ADDR_SYNTH) begin
            // oscillator reads as on whenever synthesis is enabled
            bus.reg_rdata <= {8'h00, stream_count, 1'b0,
                              synth[DSOC_SYN_EN] | synth[DSOC_SYN_OSC],
                              synth[1:0]};
         end else if (bus.reg_addr == DSOC_ADDR_SREF) begin
            bus.reg_rdata <= {13'h0000, sref};
         end else if (bus.reg_addr == DSOC_ADDR_STAT) begin
            bus.reg_rdata <= {8'h00, synth_nch, synth_active, aligned,
                              pll_s1, link_up, fuse_done};
         end else if (bus.reg_addr == DSOC_ADDR_LANE) begin
            bus.reg_rdata <= {12'h000, lane_sync};
         end else if (bus.reg_addr == DSOC_ADDR_FREQ) begin
            bus.reg_rdata <= freq;
         end else if (bus.reg_addr == DSOC_ADDR_FREQ_R) begin
            bus.reg_rdata <= freq_r;
         end else if (bus.reg_addr == DSOC_ADDR_KM1) begin
            bus.reg_rdata <= {8'h00, km1};
         end else begin
            bus.reg_rdata <= 16'h0000;
         end
      end
   end

   // ------------------------------------------------------------
   // datapath: saturate, then add; zero code while disabled
   // ------------------------------------------------------------
   for (genvar g = 0; g < CH; g++) begin : g_ch
      logic signed [12:0] lim, sat;
      logic signed [17:0] sum;
      always_comb begin
         lim = (dith[2*g +: 2] == DSOC_DITH_OFF) ? DSOC_LIM_FULL
                                                 : DSOC_LIM_DITH;
         if (ofs[g] > lim)       sat = lim;
         else if (ofs[g] < -lim) sat = -lim;
         else                    sat = ofs[g];
         sum = 18'(sample_in[g]) + 18'(sat);
      end
      // output clips to the 16-bit code range rather than wrapping
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            dac_out[g] <= 16'sh0000;
         end else if (!ctrl[DSOC_CTRL_DP]) begin
            dac_out[g] <= 16'sh0000;
         end else if (sum > 18'sh07FFF) begin
            dac_out[g] <= 16'sh7FFF;
         end else if (sum < -18'sh08000) begin
            dac_out[g] <= -16'sh8000;
         end else begin
            dac_out[g] <= sum[15:0];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) dac_valid <= 1'b0;
      else     dac_valid <= ctrl[DSOC_CTRL_DP];
   end
endmodule

// file: src/dsoc_host.sv
module dsoc_host
   import dsoc_pkg::*;
#(
   parameter int SETTLE_CYC = DSOC_DP_SETTLE_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   dsoc_if.host             bus
);
   typedef enum logic [8:0] {
      S_IDLE = 9'h001, S_FUSE = 9'h002, S_CFG  = 9'h004,
      S_TX   = 9'h008, S_LINK = 9'h010, S_DP   = 9'h020,
      S_WAIT = 9'h040, S_SREF = 9'h080, S_RAW  = 9'h100
   } dsoc_st_t;
   dsoc_st_t st;
   logic [3:0]  step;
   logic [31:0] wait_cnt;
   logic [11:0] r_addr;
   logic [15:0] r_wdata, r_rdata, mode, ofs_val, syn_val;
   logic        r_write, done, busy;
   logic [2:0]  pulses;
   logic        acc;
   assign acc = psel && penable;

   // apb slave: zero wait states, pslverr on unmapped writes and on reads above 0x1C
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0; pslverr <= 1'b0; prdata <= 32'h0;
         r_addr <= 12'h0; r_wdata <= 16'h0; mode <= 16'h0;
         ofs_val <= 16'h0; syn_val <= 16'h0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            if (paddr == DSOC_APB_STAT)       prdata <= {30'h0, done, busy};
            else if (paddr == DSOC_APB_RDATA) prdata <= {16'h0, r_rdata};
            else if (paddr == DSOC_APB_ADDR)  prdata <= {20'h0, r_addr};
            else if (paddr == DSOC_APB_MODE)  prdata <= {16'h0, mode};
            else                              prdata <= 32'h0;
            if (pwrite && paddr != DSOC_APB_CMD && paddr != DSOC_APB_ADDR &&
                paddr != DSOC_APB_WDATA && paddr != DSOC_APB_MODE &&
                paddr != DSOC_APB_OFS && paddr != DSOC_APB_SYN) begin
               pslverr <= 1'b1;
            end else if (!pwrite && paddr > DSOC_APB_SYN) begin
               pslverr <= 1'b1;
               prdata  <= DSOC_APB_ERRV;
            end
         end
         // writes land at the access edge only
         if (acc && pready && pwrite) begin
            if (paddr == DSOC_APB_ADDR)       r_addr  <= pwdata[11:0];
            else if (paddr == DSOC_APB_WDATA) r_wdata <= pwdata[15:0];
            else if (paddr == DSOC_APB_MODE)  mode    <= pwdata[15:0];
            else if (paddr == DSOC_APB_OFS)   ofs_val <= pwdata[15:0];
            else if (paddr == DSOC_APB_SYN)   syn_val <= pwdata[15:0];
         end
      end
   end

   // bring-up sequencer driving the device port
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st <= S_IDLE; step <= 4'h0; wait_cnt <= 32'h0;
         bus.reg_wr <= 1'b0; bus.reg_rd <= 1'b0;
         bus.reg_addr <= 12'h0; bus.reg_wdata <= 16'h0;
         bus.tx_running <= 1'b0; bus.sysref <= 1'b0; r_write <= 1'b0;
         r_rdata <= 16'h0; done <= 1'b0; busy <= 1'b0; pulses <= 3'h0;
      end else begin
         bus.reg_wr <= 1'b0;
         bus.reg_rd <= 1'b0;
         bus.sysref <= 1'b0;
         if (bus.reg_rvalid) r_rdata <= bus.reg_rdata;
         case (st)
            S_IDLE: if (acc && pwrite && paddr == DSOC_APB_CMD) begin
               busy <= 1'b1; done <= 1'b0; step <= 4'h0;
               if (pwdata[DSOC_CMD_RAW]) begin
                  r_write <= pwdata[3];
                  st <= S_RAW;
               end else if (pwdata[DSOC_CMD_RECFG]) begin
                  // clear datapath and receiver before new setup
                  bus.reg_wr <= 1'b1; bus.reg_addr <= DSOC_ADDR_CTRL;
                  bus.reg_wdata <= 16'h0000;
                  bus.tx_running <= 1'b0;
                  busy <= 1'b0; done <= 1'b1;
               end else begin
                  st <= S_FUSE;
               end
            end
            S_RAW: begin
               bus.reg_addr <= r_addr;
               bus.reg_wdata <= r_wdata;
               if (step == 4'h0) begin
                  bus.reg_wr <= r_write; bus.reg_rd <= !r_write;
                  step <= 4'h1;
               end else if (step == 4'h3) begin
                  busy <= 1'b0; done <= 1'b1; st <= S_IDLE;
               end else step <= step + 4'h1;
            end
            S_FUSE: begin
               // poll fuse status before any setting
               bus.reg_addr <= DSOC_ADDR_STAT;
               if (step == 4'h0) begin
                  bus.reg_rd <= 1'b1; step <= 4'h1;
               end else if (bus.reg_rvalid) begin
                  step <= 4'h0;
                  if (bus.reg_rdata[DSOC_ST_FUSE]) st <= S_CFG;
               end
            end
            S_CFG: begin
               // offsets written while datapath still off
               bus.reg_wr <= 1'b1;
               step <= step + 4'h1;
               if (step == 4'h0) begin
                  bus.reg_addr <= DSOC_ADDR_OFS0; bus.reg_wdata <= ofs_val;
               end else if (step == 4'h1) begin
                  bus.reg_addr <= DSOC_ADDR_OFS1; bus.reg_wdata <= ofs_val;
               end else if (step == 4'h2) begin
                  // km1 from mode byte so it matches partner
                  bus.reg_addr <= DSOC_ADDR_KM1;
                  bus.reg_wdata <= {8'h00, mode[15:8]};
               end else begin
                  // complex synth forces 2 or 4 streams
                  bus.reg_addr <= DSOC_ADDR_SYNTH;
                  bus.reg_wdata <= syn_val[DSOC_SYN_FMT] ?
                     {8'h00, (syn_val[7:4] > 4'h2) ? 4'h4 : 4'h2,
                      syn_val[3:0]} : syn_val;
                  step <= 4'h0;
                  st <= syn_val[DSOC_SYN_EN] ? S_DP : S_TX;
               end
            end
            S_TX: begin
               bus.tx_running <= 1'b1;
               st <= S_LINK;
            end
            S_LINK: begin
               bus.reg_wr <= 1'b1; bus.reg_addr <= DSOC_ADDR_CTRL;
               bus.reg_wdata <= 16'h0002;
               st <= S_DP;
            end
            S_DP: begin
               bus.reg_wr <= 1'b1; bus.reg_addr <= DSOC_ADDR_CTRL;
               bus.reg_wdata <= syn_val[DSOC_SYN_EN] ? 16'h0001 : 16'h0003;
               wait_cnt <= 32'h0;
               st <= S_WAIT;
            end
            S_WAIT: begin
               wait_cnt <= wait_cnt + 32'h1;
               if (wait_cnt == 32'(SETTLE_CYC - 1)) begin
                  step <= 4'h0; pulses <= 3'h0;
                  if (syn_val[DSOC_SYN_EN]) begin
                     busy <= 1'b0; done <= 1'b1; st <= S_IDLE;
                  end else st <= S_SREF;
               end
            end
            S_SREF: begin
               // separate writes: wake, enable, align, pulses
               step <= step + 4'h1;
               if (step == 4'h0) begin
                  bus.reg_wr <= 1'b1; bus.reg_addr <= DSOC_ADDR_SREF;
                  bus.reg_wdata <= 16'h0000;
               end else if (step == 4'h1) begin
                  bus.reg_wr <= 1'b1; bus.reg_wdata <= 16'h0002;
               end else if (step == 4'h2) begin
                  bus.reg_wr <= 1'b1; bus.reg_wdata <= 16'h0006;
               end else if (step[0]) begin
                  bus.sysref <= 1'b1;
                  pulses <= pulses + 3'h1;
                  if (pulses == 3'(DSOC_SREF_PULSES - 1)) begin
                     busy <= 1'b0; done <= 1'b1; st <= S_IDLE;
                  end
               end
               if (step == 4'hF) step <= 4'h3;
            end
            default: st <= S_IDLE;
         endcase
      end
   end
endmodule

// file: test/dsoc_sva.sv
module dsoc_sva
   import dsoc_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [11:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic        reg_rvalid,
   input wire logic        tx_running
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] addr_q;
   logic        fuse_seen;
   logic [2:0]  ctrl_q;
   // ------------------------------------------------------------
   // shadow state
   // ------------------------------------------------------------
   // read data belongs to the address of the cycle before
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addr_q <= 12'h000;
      end else begin
         addr_q <= reg_addr;
      end
   end
   // host may write only once it has read fuse done back
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fuse_seen <= 1'b0;
      end else if (reg_rvalid && addr_q == DSOC_ADDR_STAT) begin
         fuse_seen <= fuse_seen | reg_rdata[DSOC_ST_FUSE];
      end
   end
   // last control word written by the host
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= 3'h0;
      end else if (reg_wr && reg_addr == DSOC_ADDR_CTRL) begin
         ctrl_q <= reg_wdata[2:0];
      end
   end
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   rd_answer_a: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered next cycle");
   rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
      else $error("answer without read");
   ofs_resv_a: assert property (reg_rvalid && (addr_q == DSOC_ADDR_OFS0
      || addr_q == DSOC_ADDR_OFS1) |-> reg_rdata[15:13] == 3'h0)
      else $error("offset reserved bits not zero");
   link_up_a: assert property (reg_rvalid && addr_q == DSOC_ADDR_STAT
      && reg_rdata[DSOC_ST_LINK] |-> reg_rdata[3:2] == 2'h3)
      else $error("link up without lock and alignment");
   tx_first_a: assert property (reg_wr && reg_addr == DSOC_ADDR_CTRL
      && reg_wdata[DSOC_CTRL_LINK] |-> tx_running && $past(tx_running))
      else $error("receiver enabled before transmitter");
   align_order_a: assert property (reg_wr && reg_addr == DSOC_ADDR_SREF
      && reg_wdata[2] |-> reg_wdata[1:0] == 2'h2)
      else $error("alignment enabled out of order");
   host_fuse_a: assert property (reg_wr |-> fuse_seen)
      else $error("write before fuse done seen");
   ofs_safe_a: assert property (reg_wr && reg_addr[11:1] == 11'h395
      |-> !ctrl_q[DSOC_CTRL_DP] || ctrl_q[DSOC_CTRL_BLK])
      else $error("offset changed while datapath live");
endmodule

// file: test/dac_startup_and_offset_control_tb_top.sv
module dac_startup_and_offset_control_tb_top
   import dsoc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [1:0] d; logic [15:0] o; logic [15:0] s;} dsoc_row_t;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, pll, dac_valid, e;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata, r;
   logic signed [15:0] sample_in [2];
   logic signed [15:0] dac_out [2];
   int                 n_mismatch, n_tests;
   dsoc_row_t rows [6] = '{'{2'h0, 16'h00C8, 16'h0064},
      '{2'h0, 16'h1ED4, 16'h0000}, '{2'h3, 16'h0FA0, 16'h0000},
      '{2'h3, 16'h1000, 16'h03E8}, '{2'h3, 16'h0064, 16'h7FF8},
      '{2'h1, 16'h007F, 16'hFFFB}};
   dsoc_if u_dsoc_if ();
   dsoc_device #(.CH(2)) u_dsoc_device (.clk(clk), .rst(rst),
      .bus(u_dsoc_if), .sample_in(sample_in), .pll_locked_in(pll),
      .dac_out(dac_out), .dac_valid(dac_valid));
   dsoc_host #(.SETTLE_CYC(20)) u_dsoc_host (.clk(clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus(u_dsoc_if));
   dsoc_sva u_dsoc_sva (.clk(clk), .rst(rst), .reg_wr(u_dsoc_if.reg_wr),
      .reg_rd(u_dsoc_if.reg_rd), .reg_addr(u_dsoc_if.reg_addr),
      .reg_wdata(u_dsoc_if.reg_wdata), .reg_rdata(u_dsoc_if.reg_rdata),
      .reg_rvalid(u_dsoc_if.reg_rvalid), .tx_running(u_dsoc_if.tx_running));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   always #10 clk = ~clk;
   // offset is clamped first, then the sum is clipped to 16 bits
   function automatic logic [15:0] exp_out(dsoc_row_t w);
      int lim, v;
      lim = (w.d == DSOC_DITH_OFF) ? DSOC_LIM_FULL : DSOC_LIM_DITH;
      v = $signed(w.o[12:0]);
      v = (v > lim) ? lim : ((v < -lim) ? -lim : v);
      v = v + $signed(w.s);
      v = (v > 32767) ? 32767 : ((v < -32768) ? -32768 : v);
      return v[15:0];
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // one apb transfer; answer and data are taken at the closing edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         n_mismatch++;
         give_verdict();
      end
   endtask
   task automatic wait_stat(input int b, input logic v);
      int k;
      k = 0;
      do begin
         apb(1'b0, DSOC_APB_STAT, 32'h0);
         k++;
      end while (r[b] !== v && k < 200);
      if (k >= 200) begin
         n_mismatch++;
         give_verdict();
      end
   endtask
   // device register access carried by the controller
   task automatic raw(input logic w, input logic [11:0] a,
                      input logic [15:0] d);
      apb(1'b1, DSOC_APB_ADDR, {20'h0, a});
      apb(1'b1, DSOC_APB_WDATA, {16'h0, d});
      apb(1'b1, DSOC_APB_CMD, w ? 32'hA : 32'h2);
      wait_stat(0, 1'b0);
      if (!w) apb(1'b0, DSOC_APB_RDATA, 32'h0);
   endtask
   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      {clk, rst, psel, penable, pwrite, paddr, pwdata} = {1'b0, 1'b1, 43'h0};
      sample_in = '{16'sh0000, 16'sh0000};
      pll = 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      chk({dac_valid, dac_out[0]}, 17'h0);
      raw(1'b0, DSOC_ADDR_OFS0, 16'h0);
      chk(r[15:0], 16'h0);
      $display("reset test done");
      apb(1'b1, DSOC_APB_CMD, 32'h1);
      wait_stat(1, 1'b1);
      chk(dac_valid, 1'b1);
      raw(1'b0, DSOC_ADDR_STAT, 16'h0);
      chk(r[3:0], 4'hF);
      raw(1'b1, DSOC_ADDR_CTRL, 16'h0007);
      $display("bring-up test done");
      foreach (rows[i]) begin
         raw(1'b1, DSOC_ADDR_DITH, {12'h0, 2'h3, rows[i].d});
         raw(1'b1, DSOC_ADDR_OFS0, rows[i].o);
         sample_in[0] <= rows[i].s;
         repeat (4) @(posedge clk);
         chk({16'h0, dac_out[0]}, exp_out(rows[i]));
      end
      $display("offset table test done");
      raw(1'b1, DSOC_ADDR_OFS1, 16'hFFFF);
      raw(1'b0, DSOC_ADDR_OFS1, 16'h0);
      chk(r[15:0], 16'h1FFF);
      chk({16'h0, dac_out[1]}, 16'hFFFF);
      apb(1'b0, 8'h40, 32'h0);
      chk(e, 1'b1);
      chk(r, DSOC_APB_ERRV);
      pll <= 1'b0;
      repeat (4) @(posedge clk);
      raw(1'b0, DSOC_ADDR_STAT, 16'h0);
      chk(r[3:0], 4'h9);
      pll <= 1'b1;
      $display("reserved bits and unmapped test done");
      apb(1'b1, DSOC_APB_CMD, 32'h4);
      wait_stat(0, 1'b0);
      repeat (4) @(posedge clk);
      chk({dac_valid, dac_out[0]}, 17'h0);
      raw(1'b1, DSOC_ADDR_SYNTH, 16'h0041);
      raw(1'b0, DSOC_ADDR_STAT, 16'h0);
      chk(r[4], 1'b0);
      raw(1'b1, DSOC_ADDR_CTRL, 16'h0001);
      raw(1'b0, DSOC_ADDR_STAT, 16'h0);
      chk(r[7:4], 4'h5);
      raw(1'b1, DSOC_ADDR_FREQ, 16'h1234);
      raw(1'b0, DSOC_ADDR_FREQ_R, 16'h0);
      chk(r[15:0], 16'h0);
      raw(1'b1, DSOC_ADDR_RESYNC, 16'h0);
      raw(1'b0, DSOC_ADDR_FREQ_R, 16'h0);
      chk(r[15:0], 16'h1234);
      $display("reconfigure and synthesis test done");
      give_verdict();
   end
endmodule
